// ===== src/scs_sequencer.sv
/*
 * scs_sequencer: start-source selection, conversion clock divider,
 * track/convert sequencing and register file of a 10-bit SAR converter.
 * Assumes timer overflow inputs are one-cycle pulses, the start pin and
 * all other inputs are synchronous to CLK, and RESULT_CODE holds the
 * analog core's finished code when the conversion phase ends.
 */
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/10ps

module scs_sequencer #(
	parameter int ADDR_W = 12,
	parameter logic [7:0] CONV_CLOCKS = 8'h0B
) (
	input logic CLK,
	input logic RESET,
	input logic CE,
	input logic [ADDR_W-1:0] S_AXI_AWADDR,
	input logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input logic [31:0] S_AXI_WDATA,
	input logic [3:0] S_AXI_WSTRB,
	input logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input logic S_AXI_BREADY,
	input logic [ADDR_W-1:0] S_AXI_ARADDR,
	input logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input logic S_AXI_RREADY,
	input logic TIMER0_OVERFLOW,
	input logic TIMER1_OVERFLOW,
	input logic TIMER2_LOW_OVERFLOW,
	input logic TIMER2_HIGH_OVERFLOW,
	input logic TIMER2_SPLIT_MODE,
	input logic TIMER3_LOW_OVERFLOW,
	input logic TIMER3_HIGH_OVERFLOW,
	input logic TIMER3_SPLIT_MODE,
	input logic EXTERNAL_START_PIN,
	input logic STANDBY,
	input logic [9:0] RESULT_CODE,
	output logic TRACK,
	output logic CONVERTING,
	output logic CONVERSION_DONE_EVENT,
	output logic [4:0] POSITIVE_INPUT_CODE,
	output logic [4:0] NEGATIVE_INPUT_CODE
);
	import scs_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic enable;
		logic track_mode;
		logic done;
		logic justify;
		logic [2:0] source;
		logic [4:0] divisor;
		logic [4:0] pos_sel;
		logic [4:0] neg_sel;
		logic [15:0] result;
		scs_state_e st;
		logic [4:0] div_cnt;
		logic [7:0] sar_cnt;
		logic pin_prev;
		logic done_evt;
		logic track;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} scs_state_s;

	scs_state_s s;
	scs_state_s next_s;

	// ----------------------------------------------------------------
	// address decode, shared by read and write
	// ----------------------------------------------------------------
	function automatic scs_reg_e decode(input logic [ADDR_W-1:0] a);
		logic [9:0] idx;
		idx = a[ADDR_W-1:2];
		if (a[1:0] != 2'h0) begin
			decode = REG_NONE;
		end else if (idx == {2'h0, IDX_CONTROL}) begin
			decode = REG_CONTROL;
		end else if (idx == {2'h0, IDX_NEG_SELECT}) begin
			decode = REG_NEG_SELECT;
		end else if (idx == {2'h0, IDX_POS_SELECT}) begin
			decode = REG_POS_SELECT;
		end else if (idx == {2'h0, IDX_CONFIG}) begin
			decode = REG_CONFIG;
		end else if (idx == {2'h0, IDX_RESULT_LOW}) begin
			decode = REG_RESULT_LOW;
		end else if (idx == {2'h0, IDX_RESULT_HIGH}) begin
			decode = REG_RESULT_HIGH;
		end else begin
			decode = REG_NONE;
		end
	endfunction

	logic wr_go;
	logic rd_go;
	scs_reg_e wr_reg;
	scs_reg_e rd_reg;
	logic [7:0] ctl_read;
	logic sar_tick;
	logic trigger;
	logic sw_start;
	logic start;
	logic single_ended;
	logic [15:0] formatted;

	// write address and data are taken together so either arrival order works
	assign wr_go = S_AXI_AWVALID && S_AXI_WVALID && !s.bvalid;
	assign rd_go = S_AXI_ARVALID && !s.rvalid;
	assign wr_reg = decode(S_AXI_AWADDR);
	assign rd_reg = decode(S_AXI_ARADDR);

	assign ctl_read = {s.enable, s.track_mode, s.done, CONVERTING, s.source, s.justify};

	// ----------------------------------------------------------------
	// start source and conversion clock
	// ----------------------------------------------------------------
	assign sar_tick = (s.div_cnt == s.divisor);
	assign sw_start = wr_go && (wr_reg == REG_CONTROL) && S_AXI_WSTRB[0] && S_AXI_WDATA[CTL_BUSY];

	always_comb begin
		case (scs_source_e'(s.source))
			SRC_SOFTWARE: trigger = sw_start;
			SRC_TIMER0: trigger = TIMER0_OVERFLOW;
			SRC_TIMER1: trigger = TIMER1_OVERFLOW;
			SRC_TIMER2: trigger = TIMER2_SPLIT_MODE ? TIMER2_LOW_OVERFLOW : TIMER2_HIGH_OVERFLOW;
			SRC_TIMER3: trigger = TIMER3_SPLIT_MODE ? TIMER3_LOW_OVERFLOW : TIMER3_HIGH_OVERFLOW;
			SRC_EXT_PIN: trigger = EXTERNAL_START_PIN && !s.pin_prev;
			default: trigger = 1'b0;
		endcase
	end

	// triggers outside idle fall on the floor; nothing is queued
	assign start = s.enable && (s.st == ST_IDLE) && trigger;

	// ----------------------------------------------------------------
	// result formatting
	// ----------------------------------------------------------------
	assign single_ended = (s.neg_sel == NEG_GROUND);

	always_comb begin
		if (s.justify) begin
			formatted = {RESULT_CODE, 6'h00};
		end else if (single_ended) begin
			formatted = {6'h00, RESULT_CODE};
		end else begin
			formatted = {{6{RESULT_CODE[9]}}, RESULT_CODE};
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.done_evt = 1'b0;
		next_s.pin_prev = EXTERNAL_START_PIN;

		// bus responses
		if (s.bvalid && S_AXI_BREADY) begin
			next_s.bvalid = 1'b0;
		end
		if (s.rvalid && S_AXI_RREADY) begin
			next_s.rvalid = 1'b0;
		end
		if (wr_go) begin
			next_s.bvalid = 1'b1;
			next_s.bresp = (wr_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
			if (S_AXI_WSTRB[0]) begin
				if (wr_reg == REG_CONTROL) begin
					next_s.enable = S_AXI_WDATA[CTL_ENABLE];
					next_s.track_mode = S_AXI_WDATA[CTL_TRACK_MODE];
					next_s.source = S_AXI_WDATA[CTL_SRC_LSB +: 3];
					next_s.justify = S_AXI_WDATA[CTL_JUSTIFY];
					// writing zero clears the flag; writing one leaves it alone
					if (!S_AXI_WDATA[CTL_DONE]) begin
						next_s.done = 1'b0;
					end
				end else if (wr_reg == REG_NEG_SELECT) begin
					next_s.neg_sel = S_AXI_WDATA[4:0];
				end else if (wr_reg == REG_POS_SELECT) begin
					next_s.pos_sel = S_AXI_WDATA[4:0];
				end else if (wr_reg == REG_CONFIG) begin
					next_s.divisor = S_AXI_WDATA[CFG_DIV_LSB +: 5];
				end
			end
		end
		if (rd_go) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = RESP_OKAY;
			if (rd_reg == REG_CONTROL) begin
				next_s.rdata = {24'h000000, ctl_read};
			end else if (rd_reg == REG_NEG_SELECT) begin
				next_s.rdata = {27'h0000000, s.neg_sel};
			end else if (rd_reg == REG_POS_SELECT) begin
				next_s.rdata = {27'h0000000, s.pos_sel};
			end else if (rd_reg == REG_CONFIG) begin
				next_s.rdata = {24'h000000, s.divisor, 3'h0};
			end else if (rd_reg == REG_RESULT_LOW) begin
				next_s.rdata = {24'h000000, s.result[7:0]};
			end else if (rd_reg == REG_RESULT_HIGH) begin
				next_s.rdata = {24'h000000, s.result[15:8]};
			end else begin
				next_s.rdata = 32'h00000000;
				next_s.rresp = RESP_SLVERR;
			end
		end

		// divider runs only during a conversion so each starts on a fresh phase
		if (s.st == ST_IDLE || sar_tick) begin
			next_s.div_cnt = 5'h00;
		end else begin
			next_s.div_cnt = s.div_cnt + 5'h01;
		end

		case (s.st)
			ST_IDLE: begin
				next_s.sar_cnt = 8'h00;
				if (start) begin
					// the pin source in low-power mode has already tracked while low
					if (s.track_mode && s.source != SRC_EXT_PIN) begin
						next_s.st = ST_TRACK;
					end else begin
						next_s.st = ST_CONVERT;
					end
				end
			end
			ST_TRACK: begin
				if (sar_tick) begin
					if (s.sar_cnt == LP_TRACK_CLOCKS - 8'h01) begin
						next_s.sar_cnt = 8'h00;
						next_s.st = ST_CONVERT;
					end else begin
						next_s.sar_cnt = s.sar_cnt + 8'h01;
					end
				end
			end
			ST_CONVERT: begin
				if (sar_tick) begin
					if (s.sar_cnt == CONV_CLOCKS - 8'h01) begin
						next_s.sar_cnt = 8'h00;
						next_s.st = ST_IDLE;
						next_s.result = formatted;
						next_s.done = 1'b1;
						next_s.done_evt = 1'b1;
					end else begin
						next_s.sar_cnt = s.sar_cnt + 8'h01;
					end
				end
			end
			default: next_s.st = ST_IDLE;
		endcase

		// disabling aborts any conversion and parks the converter
		if (!s.enable) begin
			next_s.st = ST_IDLE;
			next_s.sar_cnt = 8'h00;
		end

		// tracking switch for the sample stage
		if (!next_s.enable || STANDBY) begin
			next_s.track = 1'b0;
		end else if (!next_s.track_mode) begin
			next_s.track = (next_s.st != ST_CONVERT);
		end else if (next_s.source == SRC_EXT_PIN) begin
			next_s.track = (next_s.st == ST_IDLE) && !EXTERNAL_START_PIN;
		end else begin
			next_s.track = (next_s.st == ST_TRACK);
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (RESET) begin
			s <= '0;
			s.divisor <= DIVISOR_RESET;
			s.pos_sel <= SELECT_RESET;
			s.neg_sel <= SELECT_RESET;
			s.st <= ST_IDLE;
		end else if (CE) begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign S_AXI_AWREADY = wr_go;
	assign S_AXI_WREADY = wr_go;
	assign S_AXI_BVALID = s.bvalid;
	assign S_AXI_BRESP = s.bresp;
	assign S_AXI_ARREADY = rd_go;
	assign S_AXI_RVALID = s.rvalid;
	assign S_AXI_RRESP = s.rresp;
	assign S_AXI_RDATA = s.rdata;
	assign CONVERTING = (s.st != ST_IDLE);
	assign TRACK = s.track;
	assign CONVERSION_DONE_EVENT = s.done_evt;
	assign POSITIVE_INPUT_CODE = s.pos_sel;
	assign NEGATIVE_INPUT_CODE = s.neg_sel;
endmodule

// ===== src/scs_pkg.sv
/*
 * scs_pkg: constants and types shared by the converter sequencer.
 * Assumes a 32-bit AXI4-Lite register bus; every register index is
 * multiplied by four to form its byte address.
 */
package scs_pkg;
	// ----------------------------------------------------------------
	// register indices (byte address = index * 4)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_CONTROL = 8'hE8;
	localparam logic [7:0] IDX_NEG_SELECT = 8'hBA;
	localparam logic [7:0] IDX_POS_SELECT = 8'hBB;
	localparam logic [7:0] IDX_CONFIG = 8'hBC;
	localparam logic [7:0] IDX_RESULT_LOW = 8'hBD;
	localparam logic [7:0] IDX_RESULT_HIGH = 8'hBE;

	// ----------------------------------------------------------------
	// control and config register bit positions
	// ----------------------------------------------------------------
	localparam int CTL_ENABLE = 7;
	localparam int CTL_TRACK_MODE = 6;
	localparam int CTL_DONE = 5;
	localparam int CTL_BUSY = 4;
	localparam int CTL_SRC_LSB = 1;
	localparam int CTL_JUSTIFY = 0;
	localparam int CFG_DIV_LSB = 3;

	// ----------------------------------------------------------------
	// reset values and counts
	// ----------------------------------------------------------------
	localparam logic [4:0] DIVISOR_RESET = 5'h1F;
	localparam logic [4:0] SELECT_RESET = 5'h00;
	localparam logic [4:0] NEG_GROUND = 5'h1F;
	localparam logic [7:0] LP_TRACK_CLOCKS = 8'h03;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		SRC_SOFTWARE,
		SRC_TIMER0,
		SRC_TIMER2,
		SRC_TIMER1,
		SRC_EXT_PIN,
		SRC_TIMER3
	} scs_source_e;

	typedef enum logic [2:0] {
		REG_NONE,
		REG_CONTROL,
		REG_NEG_SELECT,
		REG_POS_SELECT,
		REG_CONFIG,
		REG_RESULT_LOW,
		REG_RESULT_HIGH
	} scs_reg_e;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_TRACK,
		ST_CONVERT
	} scs_state_e;
endpackage

// ===== verification/scs_sequencer_props.sv
/* scs_sequencer_props: assertions on the sequencer's bus and conversion ports.
   assumes it is bound onto scs_sequencer with CE held high */
`timescale 1ns/10ps
module scs_sequencer_props #(
	parameter logic [7:0] CONV_CLOCKS = 8'h0B
) (
	input logic CLK,
	input logic RESET,
	input logic S_AXI_AWVALID,
	input logic S_AXI_AWREADY,
	input logic [1:0] S_AXI_BRESP,
	input logic S_AXI_BVALID,
	input logic S_AXI_BREADY,
	input logic S_AXI_ARVALID,
	input logic S_AXI_ARREADY,
	input logic [31:0] S_AXI_RDATA,
	input logic S_AXI_RVALID,
	input logic S_AXI_RREADY,
	input logic STANDBY,
	input logic TRACK,
	input logic CONVERTING,
	input logic CONVERSION_DONE_EVENT
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	write_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=> S_AXI_BVALID)
		else $error("write not answered");
	read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read not answered");
	bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped");
	rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped");
	done_on_fall_a: assert property (CONVERSION_DONE_EVENT |-> $fell(CONVERTING))
		else $error("done without busy fall");
	done_pulse_a: assert property (CONVERSION_DONE_EVENT |=> !CONVERSION_DONE_EVENT)
		else $error("done pulse too long");
	standby_track_a: assert property (STANDBY |=> !TRACK)
		else $error("tracking in standby");
	busy_bound_a: assert property ($rose(CONVERTING) |-> ##[1:600] !CONVERTING)
		else $error("conversion never ends");
	cover property (CONVERSION_DONE_EVENT);
	cover property (S_AXI_BVALID && S_AXI_BREADY);
	cover property (STANDBY && !TRACK);
endmodule

bind scs_sequencer scs_sequencer_props #(.CONV_CLOCKS(CONV_CLOCKS)) u_props (.CLK(CLK), .RESET(RESET),
	.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_BRESP(S_AXI_BRESP),
	.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
	.S_AXI_RREADY(S_AXI_RREADY), .STANDBY(STANDBY), .TRACK(TRACK), .CONVERTING(CONVERTING),
	.CONVERSION_DONE_EVENT(CONVERSION_DONE_EVENT));

// ===== verification/scs_far_side.sv
/* scs_far_side: timers, start pin and analog core beside the sequencer.
   assumes fire is a one-cycle request from the bench */
`timescale 1ns/10ps
module scs_far_side (
	input logic clk,
	input logic fire,
	input logic [2:0] line,
	input logic busy,
	input logic [9:0] code,
	output logic [6:0] pulse,
	output logic [9:0] result
);
	// overflows are one-cycle pulses; line 6 is a brief high on the start pin
	always @(posedge clk) begin
		pulse <= fire ? 7'h01 << line : 7'h00;
		// the code is only meaningful while converting, so it toggles otherwise
		result <= busy ? code : ~result;
	end
endmodule

// ===== verification/scs_sequencer_tb.sv
/* scs_sequencer_tb: random conversions from every start source, plus registers.
   assumes scs_pkg and scs_far_side are compiled first */
`timescale 1ns/10ps
module scs_sequencer_tb;
	import scs_pkg::*;
	localparam int CC = 2;
	logic clk = 0, rst = 1, stby = 0, fire = 0, s2 = 0, s3 = 0, awv = 0, wv = 0, arv = 0, brdy = 0, rrdy = 0;
	logic awr, wrdy, bv, arr, rv, trk, busy, dev;
	logic [11:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rdd, seed = 32'hE095;
	logic [1:0] br, rr;
	logic [6:0] pul;
	logic [9:0] res, code = 0;
	logic [2:0] ln = 0;
	logic [4:0] pos, neg;
	int failures = 0, n_compared = 0, cyc = 0;
	always #50 clk = ~clk;
	scs_sequencer #(.CONV_CLOCKS(8'(CC))) dut (.CLK(clk), .RESET(rst), .CE(1'b1), .S_AXI_AWADDR(awa),
		.S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wrdy), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy), .S_AXI_ARADDR(ara),
		.S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
		.S_AXI_RREADY(rrdy), .TIMER0_OVERFLOW(pul[0]), .TIMER1_OVERFLOW(pul[1]), .TIMER2_LOW_OVERFLOW(pul[2]),
		.TIMER2_HIGH_OVERFLOW(pul[3]), .TIMER2_SPLIT_MODE(s2), .TIMER3_LOW_OVERFLOW(pul[4]),
		.TIMER3_HIGH_OVERFLOW(pul[5]), .TIMER3_SPLIT_MODE(s3), .EXTERNAL_START_PIN(pul[6]), .STANDBY(stby),
		.RESULT_CODE(res), .TRACK(trk), .CONVERTING(busy), .CONVERSION_DONE_EVENT(dev),
		.POSITIVE_INPUT_CODE(pos), .NEGATIVE_INPUT_CODE(neg));
	scs_far_side far (.clk(clk), .fire(fire), .line(ln), .busy(busy), .code(code), .pulse(pul), .result(res));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function logic [15:0] exp_res(logic [9:0] c, logic lj, logic df);
		if (lj)
			return {c, 6'h00};
		return df ? {{6{c[9]}}, c} : {6'h00, c};
	endfunction
	function logic [11:0] ad(logic [7:0] i);
		return {2'b00, i, 2'b00};
	endfunction
	// alt picks the overflow that the timer's mode does not use
	function logic [2:0] line_of(logic [2:0] s, logic alt);
		case (s)
			1: return 3'h0;
			3: return 3'h1;
			2: return (s2 ^ alt) ? 3'h2 : 3'h3;
			5: return (s3 ^ alt) ? 3'h4 : 3'h5;
			default: return 3'h6;
		endcase
	endfunction
	task chk(string nm, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(logic [11:0] a, logic [31:0] d, output logic [1:0] r);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		// each channel is released at the edge that takes it
		while (!(aw_ok && w_ok)) begin
			@(posedge clk);
			if (awr === 1'b1) aw_ok = 1'b1;
			if (wrdy === 1'b1) w_ok = 1'b1;
			if (aw_ok) awv <= 1'b0;
			if (w_ok) wv <= 1'b0;
		end
		@(posedge clk);
		brdy <= 1'b1;
		do @(posedge clk); while (bv !== 1'b1);
		r = br;
		brdy <= 1'b0;
	endtask
	task rd(logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		ara <= a;
		arv <= 1'b1;
		do @(posedge clk); while (arr !== 1'b1);
		arv <= 1'b0;
		@(posedge clk);
		rrdy <= 1'b1;
		do @(posedge clk); while (rv !== 1'b1);
		d = rdd;
		r = rr;
		rrdy <= 1'b0;
	endtask
	task fire_ln(logic [2:0] l);
		ln <= l;
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
	endtask
	// for every source but software, a second trigger lands early in the conversion and must be ignored
	task measure(logic [2:0] s, output int n);
		while (busy !== 1'b1) @(posedge clk);
		if (s != 0) fire_ln(line_of(s, 0));
		else @(posedge clk);
		n = 1;
		while (busy === 1'b1) begin
			n++;
			@(posedge clk);
		end
		chk("done pulse", dev, 1);
	endtask
	task results();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			results();
		end
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] d, e;
		logic [1:0] r;
		logic [7:0] ctl;
		logic [2:0] src;
		logic [4:0] dv;
		logic df;
		int len, cnt;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("pos reset", pos, 5'h00);
		rd(ad(IDX_CONFIG), d, r);
		chk("config reset", d, 32'hF8);
		rd(12'h004, d, r);
		chk("unmapped read", {d[29:0], r}, {30'h0, RESP_SLVERR});
		wr(12'h004, 32'h1, r);
		chk("unmapped write", r, RESP_SLVERR);
		ctl = 8'(rnd());
		wr(ad(IDX_POS_SELECT), {24'h0, ctl}, r);
		rd(ad(IDX_POS_SELECT), d, r);
		chk("pos select", d, {27'h0, ctl[4:0]});
		chk("pos code", pos, ctl[4:0]);
		for (int i = 0; i < 12; i++) begin
			d = rnd();
			df = d[2];
			src = 3'(i % 6);
			dv = {3'h0, d[4:3]} + 5'h01;
			code <= d[14:5];
			s2 <= d[15];
			s3 <= d[16];
			ctl = {1'b1, d[0], 2'b00, src, d[1]};
			wr(ad(IDX_NEG_SELECT), df ? 32'h0 : 32'h1F, r);
			chk("neg code", neg, df ? 5'h00 : 5'h1F);
			wr(ad(IDX_CONFIG), {24'h0, dv, 3'h0}, r);
			// enable and source must already stand before a software start
			wr(ad(IDX_CONTROL), {24'h0, ctl}, r);
			if (src == 2 || src == 5) begin
				fire_ln(line_of(src, 1));
				repeat (4) @(posedge clk);
				chk("unused overflow", busy, 0);
			end
			len = (d[0] && src != 4 ? 3 + CC : CC) * (dv + 1);
			fork
				if (src == 0) wr(ad(IDX_CONTROL), {24'h0, ctl | 8'h10}, r);
				else fire_ln(line_of(src, 0));
				measure(src, cnt);
			join
			chk("busy cycles", cnt, len);
			repeat (4) @(posedge clk);
			chk("retrigger", busy, 0);
			rd(ad(IDX_CONTROL), d, r);
			chk("control", d, {24'h0, ctl | 8'h20});
			rd(ad(IDX_RESULT_HIGH), d, r);
			rd(ad(IDX_RESULT_LOW), e, r);
			chk("result", {d[7:0], e[7:0]}, exp_res(code, ctl[0], df));
			chk("track idle", trk, !ctl[6] || src == 4);
			// spacing keeps the sample rate within the converter's limit
			repeat (40) @(posedge clk);
		end
		wr(ad(IDX_CONTROL), 32'h80, r);
		chk("track on", trk, 1);
		stby <= 1'b1;
		repeat (2) @(posedge clk);
		chk("standby track", trk, 0);
		stby <= 1'b0;
		wr(ad(IDX_CONTROL), 32'h0, r);
		wr(ad(IDX_CONTROL), 32'h10, r);
		chk("disabled", busy, 0);
		chk("disabled track", trk, 0);
		results();
	end
endmodule
